// File: rtl/bbs_exec.sv
/*
 Execution slice: compare immediate, skips, relative branches,
 I/O bit set/clear, shifts, rotates and nibble swap.
 Operands arrive with the issue strobe from core logic on the same clock;
 the core applies results when the done pulse shows.
*/
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module bbs_exec
(
   input wire logic I_CLK_SYS,
   input wire logic I_RESETN,
   input wire logic I_ISSUE,
   input wire bbs_pkg::bbs_op_type I_OP,
   input wire logic [15:0] I_PC,
   input wire logic I_TWO_WORD,
   input wire logic [7:0] I_RD_VAL,
   input wire logic [7:0] I_IMM,
   input wire logic [2:0] I_BIT,
   input wire logic [6:0] I_OFFSET,
   input wire logic [5:0] I_IO_ADDR,
   input wire logic [7:0] I_IO_VAL,
   input wire logic [7:0] I_STATUS_REG,
   input wire logic [3:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic O_DONE,
   output logic O_BUSY,
   output logic O_TAKEN,
   output logic [15:0] O_PC_NEXT,
   output logic [7:0] O_RESULT,
   output logic O_RES_WE,
   output logic [7:0] O_STATUS_REG,
   output logic O_STATUS_WE,
   output logic [5:0] O_IO_ADDR,
   output logic [7:0] O_IO_WDATA,
   output logic O_IO_WE,
   output logic [7:0] O_RDATA
);
   import bbs_pkg::*;

   bbs_state_type state_reg;
   logic [1:0] cnt_reg;
   logic [7:0] ctrl_reg;
   logic [7:0] taken_cnt_reg;
   logic last_taken_reg;
   logic issue_ok;
   logic pub_now;
   logic pub_late;
   logic publish;
   logic [15:0] k_ext;
   logic [15:0] br_pc;
   logic [15:0] skip_pc;
   logic [1:0] skip_cyc;
   logic [8:0] diff;
   logic [7:0] bmask;
   logic [7:0] res_next;
   logic [7:0] status_register_next;
   logic [7:0] io_wdata_next;
   logic [15:0] pc_next;
   logic [1:0] cyc_next;
   logic res_we_next;
   logic status_register_we_next;
   logic io_we_next;
   logic taken_next;
   logic is_br;
   logic cond;
   logic shf;
   logic sc;
   logic [7:0] p_res_reg;
   logic [7:0] p_status_register_reg;
   logic [7:0] p_io_wdata_reg;
   logic [15:0] p_pc_reg;
   logic p_res_we_reg;
   logic p_status_register_we_reg;
   logic p_io_we_reg;
   logic p_taken_reg;
   logic [5:0] p_io_addr_reg;

   // Issue is refused while busy or while disabled by software
   assign issue_ok = I_ISSUE && (state_reg == ST_IDLE) && ctrl_reg[CTRL_EN_BIT];
   assign pub_now = issue_ok && (cyc_next == CYC_ONE);
   assign pub_late = (state_reg == ST_WAIT) && (cnt_reg == CYC_ONE);
   assign publish = pub_now || pub_late;

   // Targets: offset is signed, so backward branches work
   assign k_ext = {{9{I_OFFSET[6]}}, I_OFFSET};
   assign br_pc = I_PC + k_ext + PC_STEP_ONE;
   assign skip_pc = I_TWO_WORD ? I_PC + PC_STEP_THREE : I_PC + PC_STEP_TWO;
   assign skip_cyc = I_TWO_WORD ? CYC_THREE : CYC_TWO;
   assign diff = {1'b0, I_RD_VAL} - {1'b0, I_IMM};
   assign bmask = 8'h01 << I_BIT;

   // Per-operation results; flags default to unchanged
   always_comb
   begin
      res_next = I_RD_VAL;
      status_register_next = I_STATUS_REG;
      io_wdata_next = I_IO_VAL;
      pc_next = I_PC + PC_STEP_ONE;
      cyc_next = CYC_ONE;
      res_we_next = 1'b0;
      status_register_we_next = 1'b0;
      io_we_next = 1'b0;
      taken_next = 1'b0;
      is_br = 1'b0;
      cond = 1'b0;
      shf = 1'b0;
      sc = 1'b0;
      case (I_OP)
         OP_COMPARE_IMMEDIATE:
         begin
            // Borrow terms; no write back of the difference
            status_register_we_next = 1'b1;
            status_register_next[FLAG_C] = diff[8];
            status_register_next[FLAG_Z] = (diff[7:0] == 8'h00);
            status_register_next[FLAG_N] = diff[7];
            status_register_next[FLAG_V] = (I_RD_VAL[7] & ~I_IMM[7] & ~diff[7])
               | (~I_RD_VAL[7] & I_IMM[7] & diff[7]);
            status_register_next[FLAG_H] = (~I_RD_VAL[3] & I_IMM[3]) | (I_IMM[3] & diff[3])
               | (diff[3] & ~I_RD_VAL[3]);
         end
         OP_SKIP_IO_BIT_CLEAR:
         begin
            if ((I_IO_VAL & bmask) == 8'h00)
            begin
               pc_next = skip_pc;
               cyc_next = skip_cyc;
               taken_next = 1'b1;
            end
         end
         OP_SKIP_REG_BIT_SET:
         begin
            if ((I_RD_VAL & bmask) != 8'h00)
            begin
               pc_next = skip_pc;
               cyc_next = skip_cyc;
               taken_next = 1'b1;
            end
         end
         OP_BRANCH_FLAG_SET:
         begin
            is_br = 1'b1;
            cond = I_STATUS_REG[I_BIT];
         end
         OP_BRANCH_EQUAL:
         begin
            is_br = 1'b1;
            cond = I_STATUS_REG[FLAG_Z];
         end
         OP_BRANCH_NOT_EQUAL:
         begin
            is_br = 1'b1;
            cond = ~I_STATUS_REG[FLAG_Z];
         end
         OP_BRANCH_CARRY_ON:
         begin
            is_br = 1'b1;
            cond = I_STATUS_REG[FLAG_C];
         end
         OP_BRANCH_CARRY_OFF:
         begin
            is_br = 1'b1;
            cond = ~I_STATUS_REG[FLAG_C];
         end
         OP_BRANCH_SIGNED_GE:
         begin
            is_br = 1'b1;
            cond = ~(I_STATUS_REG[FLAG_N] ^ I_STATUS_REG[FLAG_V]);
         end
         OP_BRANCH_SIGNED_LT:
         begin
            is_br = 1'b1;
            cond = I_STATUS_REG[FLAG_N] ^ I_STATUS_REG[FLAG_V];
         end
         OP_BRANCH_NEGATIVE:
         begin
            is_br = 1'b1;
            cond = I_STATUS_REG[FLAG_N];
         end
         OP_BRANCH_POSITIVE:
         begin
            is_br = 1'b1;
            cond = ~I_STATUS_REG[FLAG_N];
         end
         OP_BRANCH_HALF_CARRY_ON:
         begin
            is_br = 1'b1;
            cond = I_STATUS_REG[FLAG_H];
         end
         OP_BRANCH_HALF_CARRY_OFF:
         begin
            is_br = 1'b1;
            cond = ~I_STATUS_REG[FLAG_H];
         end
         OP_BRANCH_IRQ_ON:
         begin
            is_br = 1'b1;
            cond = I_STATUS_REG[FLAG_I];
         end
         OP_BRANCH_IRQ_OFF:
         begin
            is_br = 1'b1;
            cond = ~I_STATUS_REG[FLAG_I];
         end
         OP_SET_IO_BIT:
         begin
            io_we_next = 1'b1;
            io_wdata_next = I_IO_VAL | bmask;
            cyc_next = CYC_TWO;
         end
         OP_CLEAR_IO_BIT:
         begin
            io_we_next = 1'b1;
            io_wdata_next = I_IO_VAL & ~bmask;
            cyc_next = CYC_TWO;
         end
         OP_SHIFT_LEFT_LOGICAL:
         begin
            shf = 1'b1;
            res_next = {I_RD_VAL[6:0], 1'b0};
            sc = I_RD_VAL[7];
         end
         OP_SHIFT_RIGHT_LOGICAL:
         begin
            shf = 1'b1;
            res_next = {1'b0, I_RD_VAL[7:1]};
            sc = I_RD_VAL[0];
         end
         OP_ROTATE_LEFT_CARRY:
         begin
            shf = 1'b1;
            res_next = {I_RD_VAL[6:0], I_STATUS_REG[FLAG_C]};
            sc = I_RD_VAL[7];
         end
         OP_ROTATE_RIGHT_CARRY:
         begin
            shf = 1'b1;
            res_next = {I_STATUS_REG[FLAG_C], I_RD_VAL[7:1]};
            sc = I_RD_VAL[0];
         end
         OP_SHIFT_RIGHT_ARITH:
         begin
            shf = 1'b1;
            res_next = {I_RD_VAL[7], I_RD_VAL[7:1]};
            sc = I_RD_VAL[0];
         end
         OP_SWAP_NIBBLES:
         begin
            res_we_next = 1'b1;
            res_next = {I_RD_VAL[3:0], I_RD_VAL[7:4]};
         end
         default:
         begin
            cyc_next = CYC_ONE;
         end
      endcase
      // Taken branch costs one extra clock
      if (is_br && cond)
      begin
         pc_next = br_pc;
         cyc_next = CYC_TWO;
         taken_next = 1'b1;
      end
      // Shift family flags: V is N xor new carry
      if (shf)
      begin
         res_we_next = 1'b1;
         status_register_we_next = 1'b1;
         status_register_next[FLAG_C] = sc;
         status_register_next[FLAG_Z] = (res_next == 8'h00);
         status_register_next[FLAG_N] = res_next[7];
         status_register_next[FLAG_V] = res_next[7] ^ sc;
      end
   end

   // Sequencer: wait out multi-clock operations
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         state_reg <= ST_IDLE;
         cnt_reg <= 2'h0;
      end
      else if (state_reg == ST_IDLE)
      begin
         if (issue_ok && (cyc_next != CYC_ONE))
         begin
            state_reg <= ST_WAIT;
            cnt_reg <= cyc_next - CYC_ONE;
         end
      end
      else
      begin
         cnt_reg <= cnt_reg - CYC_ONE;
         if (cnt_reg == CYC_ONE)
         begin
            state_reg <= ST_IDLE;
         end
      end
   end

   // Pending results held until the last clock
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         p_res_reg <= 8'h00;
         p_status_register_reg <= 8'h00;
         p_io_wdata_reg <= 8'h00;
         p_pc_reg <= 16'h0000;
         p_res_we_reg <= 1'b0;
         p_status_register_we_reg <= 1'b0;
         p_io_we_reg <= 1'b0;
         p_taken_reg <= 1'b0;
         p_io_addr_reg <= 6'h00;
      end
      else if (issue_ok)
      begin
         p_res_reg <= res_next;
         p_status_register_reg <= status_register_next;
         p_io_wdata_reg <= io_wdata_next;
         p_pc_reg <= pc_next;
         p_res_we_reg <= res_we_next;
         p_status_register_we_reg <= status_register_we_next;
         p_io_we_reg <= io_we_next;
         p_taken_reg <= taken_next;
         p_io_addr_reg <= I_IO_ADDR;
      end
   end

   // Output stage; strobes are one-cycle pulses with done
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         O_DONE <= 1'b0;
         O_TAKEN <= 1'b0;
         O_PC_NEXT <= 16'h0000;
         O_RESULT <= 8'h00;
         O_RES_WE <= 1'b0;
         O_STATUS_REG <= 8'h00;
         O_STATUS_WE <= 1'b0;
         O_IO_ADDR <= 6'h00;
         O_IO_WDATA <= 8'h00;
         O_IO_WE <= 1'b0;
      end
      else
      begin
         O_DONE <= publish;
         O_TAKEN <= pub_now ? taken_next : pub_late && p_taken_reg;
         O_RES_WE <= pub_now ? res_we_next : pub_late && p_res_we_reg;
         O_STATUS_WE <= pub_now ? status_register_we_next : pub_late && p_status_register_we_reg;
         O_IO_WE <= pub_late && p_io_we_reg;
         if (pub_now)
         begin
            O_PC_NEXT <= pc_next;
            O_RESULT <= res_next;
            O_STATUS_REG <= status_register_next;
         end
         else if (pub_late)
         begin
            O_PC_NEXT <= p_pc_reg;
            O_RESULT <= p_res_reg;
            O_STATUS_REG <= p_status_register_reg;
            O_IO_ADDR <= p_io_addr_reg;
            O_IO_WDATA <= p_io_wdata_reg;
         end
      end
   end

   // Software control and taken-event bookkeeping
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         ctrl_reg <= CTRL_RST;
         taken_cnt_reg <= 8'h00;
         last_taken_reg <= 1'b0;
      end
      else
      begin
         if (I_WR && (I_ADDR == CTRL_OFS))
         begin
            ctrl_reg <= I_WDATA;
         end
         // Hardware count wins over a software clear in the same cycle
         if (O_DONE && O_TAKEN)
         begin
            taken_cnt_reg <= taken_cnt_reg + 8'h01;
         end
         else if (I_WR && (I_ADDR == TAKEN_OFS))
         begin
            taken_cnt_reg <= 8'h00;
         end
         if (O_DONE)
         begin
            last_taken_reg <= O_TAKEN;
         end
      end
   end

   // Busy flag mirrors the sequencer, registered
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         O_BUSY <= 1'b0;
      end
      else
      begin
         O_BUSY <= (state_reg == ST_IDLE) ? issue_ok && (cyc_next != CYC_ONE) : !pub_late;
      end
   end

   // Read port; unmapped offsets read zero
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         O_RDATA <= 8'h00;
      end
      else if (I_RD)
      begin
         if (I_ADDR == CTRL_OFS)
         begin
            O_RDATA <= ctrl_reg;
         end
         else if (I_ADDR == STAT_OFS)
         begin
            O_RDATA <= {6'h00, last_taken_reg, O_BUSY};
         end
         else if (I_ADDR == TAKEN_OFS)
         begin
            O_RDATA <= taken_cnt_reg;
         end
         else
         begin
            O_RDATA <= 8'h00;
         end
      end
   end

   // Checks on the published results
   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (!I_RESETN);

   sequence s_one_done;
      ##1 O_DONE;
   endsequence
   sequence s_two_done;
      ##1 !O_DONE ##1 O_DONE;
   endsequence

   cmp_flags_a: assert property (
      issue_ok && I_OP == OP_COMPARE_IMMEDIATE |-> s_one_done ##0 (O_STATUS_WE
      && !O_RES_WE && O_STATUS_REG[FLAG_Z] == ($past(I_RD_VAL) == $past(I_IMM))))
      else $error("compare flags wrong");
   skip_io_a: assert property (
      issue_ok && I_OP == OP_SKIP_IO_BIT_CLEAR && (I_IO_VAL & bmask) == 8'h00
      && !I_TWO_WORD |-> s_two_done ##0 (O_PC_NEXT == $past(I_PC, 2) + PC_STEP_TWO))
      else $error("io skip target wrong");
   skip_reg_a: assert property (
      issue_ok && I_OP == OP_SKIP_REG_BIT_SET && (I_RD_VAL & bmask) != 8'h00
      && I_TWO_WORD |-> ##3 (O_DONE && !O_STATUS_WE
      && O_PC_NEXT == $past(I_PC, 3) + PC_STEP_THREE))
      else $error("register skip wrong");
   flag_branch_a: assert property (
      issue_ok && I_OP == OP_BRANCH_FLAG_SET && I_STATUS_REG[I_BIT] |-> s_two_done
      ##0 (O_TAKEN && O_PC_NEXT == $past(br_pc, 2)))
      else $error("flag branch wrong");
   not_equal_a: assert property (
      issue_ok && I_OP == OP_BRANCH_NOT_EQUAL && I_STATUS_REG[FLAG_Z] |-> s_one_done
      ##0 (!O_TAKEN && O_PC_NEXT == $past(I_PC) + PC_STEP_ONE))
      else $error("not-equal fell wrong");
   signed_ge_a: assert property (
      issue_ok && I_OP == OP_BRANCH_SIGNED_GE
      && (I_STATUS_REG[FLAG_N] != I_STATUS_REG[FLAG_V]) |-> s_one_done ##0 !O_TAKEN)
      else $error("signed ge taken wrongly");
   io_set_a: assert property (
      issue_ok && I_OP == OP_SET_IO_BIT |-> s_two_done ##0 (O_IO_WE && !O_STATUS_WE
      && O_IO_WDATA == ($past(I_IO_VAL, 2) | $past(bmask, 2))))
      else $error("io set wrong");
   io_clear_a: assert property (
      issue_ok && I_OP == OP_CLEAR_IO_BIT |-> s_two_done ##0 (O_IO_WE
      && O_IO_WDATA == ($past(I_IO_VAL, 2) & ~$past(bmask, 2))))
      else $error("io clear wrong");
   shift_left_a: assert property (
      issue_ok && I_OP == OP_SHIFT_LEFT_LOGICAL |-> s_one_done ##0 (O_RES_WE
      && O_RESULT == {$past(I_RD_VAL[6:0]), 1'b0} && O_STATUS_REG[FLAG_C] == $past(I_RD_VAL[7])))
      else $error("left shift wrong");
   rotate_right_a: assert property (
      issue_ok && I_OP == OP_ROTATE_RIGHT_CARRY |-> s_one_done ##0 (O_RESULT[7]
      == $past(I_STATUS_REG[FLAG_C]) && O_STATUS_REG[FLAG_C] == $past(I_RD_VAL[0])))
      else $error("rotate right wrong");
   swap_flags_a: assert property (
      issue_ok && I_OP == OP_SWAP_NIBBLES |-> s_one_done ##0 (!O_STATUS_WE
      && O_RESULT == {$past(I_RD_VAL[3:0]), $past(I_RD_VAL[7:4])}))
      else $error("swap wrong");
endmodule

// File: rtl/bbs_pkg.sv
/*
 Shared constants and types for the branch, bit and shift execution slice.
 Assumes an 8-bit core that hands operands in and takes results back.
*/
package bbs_pkg;
   // Software register offsets and reset values
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] STAT_OFS = 4'h4;
   localparam logic [3:0] TAKEN_OFS = 4'h8;
   localparam logic [7:0] CTRL_RST = 8'h01;
   localparam int unsigned CTRL_EN_BIT = 0;
   localparam int unsigned STAT_BUSY_BIT = 0;
   localparam int unsigned STAT_TAKEN_BIT = 1;
   // Status register flag positions
   localparam int unsigned FLAG_C = 0;
   localparam int unsigned FLAG_Z = 1;
   localparam int unsigned FLAG_N = 2;
   localparam int unsigned FLAG_V = 3;
   localparam int unsigned FLAG_H = 5;
   localparam int unsigned FLAG_I = 7;
   // Cycle counts and program counter steps
   localparam logic [1:0] CYC_ONE = 2'h1;
   localparam logic [1:0] CYC_TWO = 2'h2;
   localparam logic [1:0] CYC_THREE = 2'h3;
   localparam logic [15:0] PC_STEP_ONE = 16'h0001;
   localparam logic [15:0] PC_STEP_TWO = 16'h0002;
   localparam logic [15:0] PC_STEP_THREE = 16'h0003;
   typedef enum logic [4:0] {
      OP_COMPARE_IMMEDIATE = 5'h00, OP_SKIP_IO_BIT_CLEAR = 5'h01,
      OP_SKIP_REG_BIT_SET = 5'h02, OP_BRANCH_FLAG_SET = 5'h03,
      OP_BRANCH_EQUAL = 5'h04, OP_BRANCH_NOT_EQUAL = 5'h05,
      OP_BRANCH_CARRY_ON = 5'h06, OP_BRANCH_CARRY_OFF = 5'h07,
      OP_BRANCH_SIGNED_GE = 5'h08, OP_BRANCH_SIGNED_LT = 5'h09,
      OP_BRANCH_NEGATIVE = 5'h0a, OP_BRANCH_POSITIVE = 5'h0b,
      OP_BRANCH_HALF_CARRY_ON = 5'h0c, OP_BRANCH_HALF_CARRY_OFF = 5'h0d,
      OP_BRANCH_IRQ_ON = 5'h0e, OP_BRANCH_IRQ_OFF = 5'h0f,
      OP_SET_IO_BIT = 5'h10, OP_CLEAR_IO_BIT = 5'h11,
      OP_SHIFT_LEFT_LOGICAL = 5'h12, OP_SHIFT_RIGHT_LOGICAL = 5'h13,
      OP_ROTATE_LEFT_CARRY = 5'h14, OP_ROTATE_RIGHT_CARRY = 5'h15,
      OP_SHIFT_RIGHT_ARITH = 5'h16, OP_SWAP_NIBBLES = 5'h17
   } bbs_op_type;
   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_WAIT = 1'b1
   } bbs_state_type;
endpackage

// File: bench/tb_bbs_exec.sv
/*
 Self-checking bench for the branch, bit and shift execution slice.
 Assumes the slice alone on one clock, with the bench in the core's place.
*/
`timescale 1ns/1ps
module tb_bbs_exec;
   import bbs_pkg::*;
   logic clk, resetn, issue, two_word, wr, rd;
   bbs_op_type op;
   logic [15:0] pc;
   logic [7:0] rd_val, imm, io_val, status, wdata;
   logic [2:0] bit_sel;
   logic [6:0] offset;
   logic [5:0] io_addr;
   logic [3:0] addr;
   logic o_done, o_busy, o_taken, o_res_we, o_status_we, o_io_we;
   logic [15:0] o_pc_next;
   logic [7:0] o_result, o_status_reg, o_io_wdata, o_rdata;
   logic [5:0] o_io_addr;
   // Expected values, filled by calc; tcount is counted up in run_op
   logic [15:0] exp_pc;
   logic [7:0] exp_res, exp_st, exp_io, tcount;
   logic [1:0] exp_cyc;
   logic exp_br, exp_taken, exp_res_we, exp_io_we, exp_st_we;
   logic [7:0] corners [4] = '{8'h00, 8'h80, 8'h01, 8'hff};
   int fails = 0;
   int total_checks = 0;
   int ndone = 0;
   integer seed = 32'h9573;

   bbs_exec bbs_exec_i (.I_CLK_SYS(clk), .I_RESETN(resetn), .I_ISSUE(issue), .I_OP(op),
      .I_PC(pc), .I_TWO_WORD(two_word), .I_RD_VAL(rd_val), .I_IMM(imm), .I_BIT(bit_sel),
      .I_OFFSET(offset), .I_IO_ADDR(io_addr), .I_IO_VAL(io_val), .I_STATUS_REG(status),
      .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_DONE(o_done),
      .O_BUSY(o_busy), .O_TAKEN(o_taken), .O_PC_NEXT(o_pc_next), .O_RESULT(o_result),
      .O_RES_WE(o_res_we), .O_STATUS_REG(o_status_reg), .O_STATUS_WE(o_status_we),
      .O_IO_ADDR(o_io_addr), .O_IO_WDATA(o_io_wdata), .O_IO_WE(o_io_we), .O_RDATA(o_rdata));

   // Free-running core clock, 4 ns
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Done pulses seen at each edge, for the refusal cases
   always @(posedge clk)
      if (o_done === 1'b1)
         ndone++;

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic summarize();
      if (fails == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Reference behaviour of one instruction from the current inputs
   function automatic void calc();
      logic [7:0] r;
      logic cnd, fl, sk;
      r = rd_val;
      cnd = 1'b0;
      fl = 1'b1;
      sk = 1'b0;
      exp_st = status;
      exp_br = 1'b0;
      exp_res_we = 1'b1;
      exp_io_we = 1'b0;
      exp_cyc = CYC_ONE;
      case (op)
         OP_COMPARE_IMMEDIATE:
         begin
            r = rd_val - imm;
            exp_res_we = 1'b0;
            exp_st[FLAG_H] = (~rd_val[3] & imm[3]) | (imm[3] & r[3]) | (r[3] & ~rd_val[3]);
            exp_st[FLAG_C] = (~rd_val[7] & imm[7]) | (imm[7] & r[7]) | (r[7] & ~rd_val[7]);
            exp_st[FLAG_V] = (rd_val[7] & ~imm[7] & ~r[7]) | (~rd_val[7] & imm[7] & r[7]);
         end
         OP_SHIFT_LEFT_LOGICAL: {exp_st[FLAG_C], r} = {rd_val, 1'b0};
         OP_SHIFT_RIGHT_LOGICAL: {r, exp_st[FLAG_C]} = {1'b0, rd_val};
         OP_ROTATE_LEFT_CARRY: {exp_st[FLAG_C], r} = {rd_val, status[FLAG_C]};
         OP_ROTATE_RIGHT_CARRY: {r, exp_st[FLAG_C]} = {status[FLAG_C], rd_val};
         OP_SHIFT_RIGHT_ARITH: {r, exp_st[FLAG_C]} = {rd_val[7], rd_val};
         OP_SWAP_NIBBLES:
         begin
            r = {rd_val[3:0], rd_val[7:4]};
            fl = 1'b0;
         end
         OP_SET_IO_BIT, OP_CLEAR_IO_BIT:
         begin
            exp_io = (op == OP_SET_IO_BIT) ? io_val | (8'h01 << bit_sel)
               : io_val & ~(8'h01 << bit_sel);
            exp_io_we = 1'b1;
            exp_cyc = CYC_TWO;
         end
         default:
         begin
            exp_br = 1'b1;
            case (op)
               OP_SKIP_IO_BIT_CLEAR: cnd = ~io_val[bit_sel];
               OP_SKIP_REG_BIT_SET: cnd = rd_val[bit_sel];
               OP_BRANCH_FLAG_SET: cnd = status[bit_sel];
               OP_BRANCH_EQUAL: cnd = status[FLAG_Z];
               OP_BRANCH_NOT_EQUAL: cnd = ~status[FLAG_Z];
               OP_BRANCH_CARRY_ON: cnd = status[FLAG_C];
               OP_BRANCH_CARRY_OFF: cnd = ~status[FLAG_C];
               OP_BRANCH_SIGNED_GE: cnd = ~(status[FLAG_N] ^ status[FLAG_V]);
               OP_BRANCH_SIGNED_LT: cnd = status[FLAG_N] ^ status[FLAG_V];
               OP_BRANCH_NEGATIVE: cnd = status[FLAG_N];
               OP_BRANCH_POSITIVE: cnd = ~status[FLAG_N];
               OP_BRANCH_HALF_CARRY_ON: cnd = status[FLAG_H];
               OP_BRANCH_HALF_CARRY_OFF: cnd = ~status[FLAG_H];
               OP_BRANCH_IRQ_ON: cnd = status[FLAG_I];
               default: cnd = ~status[FLAG_I];
            endcase
            sk = (op == OP_SKIP_IO_BIT_CLEAR) || (op == OP_SKIP_REG_BIT_SET);
         end
      endcase
      // Flag-free groups leave the status byte as it came in
      if (exp_br || exp_io_we)
      begin
         fl = 1'b0;
         exp_res_we = 1'b0;
      end
      exp_st_we = fl;
      if (fl)
      begin
         exp_st[FLAG_Z] = (r == 8'h00);
         exp_st[FLAG_N] = r[7];
         if (op != OP_COMPARE_IMMEDIATE)
            exp_st[FLAG_V] = r[7] ^ exp_st[FLAG_C];
      end
      exp_res = r;
      exp_taken = exp_br & cnd;
      exp_pc = pc + PC_STEP_ONE;
      if (exp_taken && sk)
      begin
         exp_pc = pc + (two_word ? PC_STEP_THREE : PC_STEP_TWO);
         exp_cyc = two_word ? CYC_THREE : CYC_TWO;
      end
      else if (exp_taken)
      begin
         exp_pc = pc + {{9{offset[6]}}, offset} + PC_STEP_ONE;
         exp_cyc = CYC_TWO;
      end
   endfunction

   // One issued instruction; the first 48 walk every code with edge operands
   task automatic run_op(input int j);
      logic [31:0] t1, t2;
      int cyc;
      t1 = $random(seed);
      t2 = $random(seed);
      @(posedge clk);
      op <= bbs_op_type'((j < 48) ? j % 24 : t1[4:0] % 5'd24);
      rd_val <= (j < 48) ? corners[j % 4] : t1[15:8];
      imm <= (j < 48) ? corners[(j / 4) % 4] : t1[31:24];
      offset <= (j < 48) ? (j[0] ? 7'h3f : 7'h40) : t1[22:16];
      pc <= (j < 48) ? 16'hffff : t2[15:0];
      status <= t2[23:16];
      io_val <= (j < 48) ? corners[j % 4] : t2[31:24];
      bit_sel <= (j < 48) ? 3'h0 : t1[7:5];
      two_word <= (j < 48) ? (j >= 24) : t1[23];
      io_addr <= t1[29:24];
      issue <= 1'b1;
      #1;
      calc();
      @(posedge clk);
      issue <= 1'b0;
      cyc = 1;
      #1;
      while (o_done !== 1'b1 && cyc < 5)
      begin
         check("busy_wait", o_busy, 1'b1);
         @(posedge clk);
         #1;
         cyc++;
      end
      check("done", o_done, 1'b1);
      check("cycles", 16'(cyc), 16'(exp_cyc));
      check("busy_done", o_busy, 1'b0);
      // Non-branch work must report not taken and a plain step
      check("taken", o_taken, exp_taken);
      check("pc_next", o_pc_next, exp_pc);
      check("res_we", o_res_we, exp_res_we);
      check("status_we", o_status_we, exp_st_we);
      if (exp_res_we)
         check("result", o_result, exp_res);
      check("status", o_status_we ? o_status_reg : status, exp_st);
      check("io_we", o_io_we, exp_io_we);
      if (exp_io_we)
      begin
         check("io_addr", o_io_addr, io_addr);
         check("io_data", o_io_wdata, exp_io);
      end
      if (exp_taken)
         tcount++;
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check("rdata", o_rdata, e);
   endtask

   // Hang guard, far beyond the few hundred cycles the run needs
   initial
   begin
      #200000;
      fails++;
      summarize();
   end

   initial
   begin
      {resetn, issue, two_word, wr, rd, pc, rd_val, imm, io_val} = '0;
      {status, wdata, bit_sel, offset, io_addr, addr} = '0;
      op = OP_COMPARE_IMMEDIATE;
      tcount = 8'h00;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      reg_rd(CTRL_OFS, CTRL_RST);
      reg_rd(4'h2, 8'h00);
      reg_wr(TAKEN_OFS, 8'h00);
      for (int j = 0; j < 180; j++)
         run_op(j);
      reg_rd(TAKEN_OFS, tcount);
      reg_rd(STAT_OFS, {6'b0, exp_taken, 1'b0});
      // Software clear of the taken counter
      reg_wr(TAKEN_OFS, 8'h00);
      reg_rd(TAKEN_OFS, 8'h00);
      // Disabled slice drops the issue
      reg_wr(CTRL_OFS, 8'h00);
      ndone = 0;
      @(posedge clk);
      op <= OP_SWAP_NIBBLES;
      issue <= 1'b1;
      @(posedge clk);
      issue <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      check("done_off", 16'(ndone), 16'h0000);
      // Second reset, driven on edges, brings the enable back
      @(posedge clk);
      resetn <= 1'b0;
      @(posedge clk);
      #1;
      check("done_rst", o_done, 1'b0);
      check("pc_rst", o_pc_next, 16'h0000);
      @(posedge clk);
      resetn <= 1'b1;
      reg_rd(CTRL_OFS, CTRL_RST);
      // Issue one cycle into a two-clock op is refused
      ndone = 0;
      @(posedge clk);
      op <= OP_SET_IO_BIT;
      issue <= 1'b1;
      @(posedge clk);
      op <= OP_COMPARE_IMMEDIATE;
      @(posedge clk);
      issue <= 1'b0;
      repeat (5) @(posedge clk);
      #1;
      check("done_busy", 16'(ndone), 16'h0001);
      summarize();
   end
endmodule
